// File: vcu_pkg.sv
package vcu_pkg;

   // Clock and bit rates
   localparam int          CLK_HZ       = 250_000_000;
   localparam int          BAUD_DEFAULT = 115_200;
   localparam int          BAUD_MIN     = 9_600;
   localparam int          BAUD_MAX     = 921_600;
   localparam int          DIV_W        = 16;
   localparam logic [15:0] DIV_DEFAULT  = 16'(CLK_HZ / BAUD_DEFAULT);
   localparam logic [15:0] DIV_LOW      = 16'(CLK_HZ / BAUD_MAX);
   localparam logic [15:0] DIV_HIGH     = 16'(CLK_HZ / BAUD_MIN);

   // Frame format
   localparam int          DATA_BITS    = 8;
   localparam logic [2:0]  LAST_BIT     = 3'(DATA_BITS - 1);
   localparam logic        LINE_IDLE    = 1'b1;
   localparam logic        LINE_START   = 1'b0;

   // Receive buffer
   localparam int          FIFO_WIDTH   = 8;
   localparam int          FIFO_DEPTH   = 32;
   localparam int          CNT_W        = 6;

   // Register map
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  REG_CTRL     = 8'h00;
   localparam logic [7:0]  REG_BAUD     = 8'h04;
   localparam logic [7:0]  REG_TXDATA   = 8'h08;
   localparam logic [7:0]  REG_RXDATA   = 8'h0C;
   localparam logic [7:0]  REG_STATUS   = 8'h10;

   // Field positions
   localparam int          CTRL_MODE_LSB  = 0;
   localparam int          RXD_VALID_BIT  = 8;
   localparam int          ST_RX_AVAIL    = 0;
   localparam int          ST_RX_FULL     = 1;
   localparam int          ST_TX_HOLD     = 2;
   localparam int          ST_TX_BUSY     = 3;
   localparam int          ST_FRAME_ERR   = 4;
   localparam int          ST_OVERRUN     = 5;
   localparam int          ST_READY       = 6;
   localparam int          ST_PERMIT      = 7;
   localparam int          ST_COUNT_LSB   = 8;

   typedef enum logic [1:0] {
      VCU_HS_NONE     = 2'b00,
      VCU_HS_THROTTLE = 2'b01,
      VCU_HS_GATE     = 2'b10,
      VCU_HS_BOTH     = 2'b11
   } vcu_mode_t;

   localparam vcu_mode_t MODE_RESET = VCU_HS_NONE;

   typedef enum logic [1:0] {
      VCU_IDLE  = 2'b00,
      VCU_START = 2'b01,
      VCU_DATA  = 2'b10,
      VCU_STOP  = 2'b11
   } vcu_fsm_t;

   function automatic logic throttle_on(input vcu_mode_t m);
      return (m == VCU_HS_THROTTLE) || (m == VCU_HS_BOTH);
   endfunction

   function automatic logic gate_on(input vcu_mode_t m);
      return (m == VCU_HS_GATE) || (m == VCU_HS_BOTH);
   endfunction

endpackage

// File: vcu_fifo.sv
module vcu_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic                         clock,
   input  wire logic                         sys_rst,
   input  wire logic                         in_valid,
   output logic                              in_ready,
   input  wire logic [WIDTH-1:0]             in_data,
   output logic                              out_valid,
   input  wire logic                         out_ready,
   output logic [WIDTH-1:0]                  out_data,
   output logic [$clog2(DEPTH):0]            count
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } vcu_fifo_state_t;

   vcu_fifo_state_t s_reg;
   vcu_fifo_state_t s_next;
   logic            push;
   logic            pop;

   assign in_ready  = s_reg.cnt != (AW+1)'(DEPTH);
   assign out_valid = s_reg.cnt != '0;
   assign out_data  = s_reg.mem[s_reg.rd];
   assign count     = s_reg.cnt;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.mem[s_reg.wr] = in_data;
         s_next.wr = (s_reg.wr == AW'(DEPTH - 1)) ? '0 : s_reg.wr + 1'b1;
      end
      if (pop) begin
         s_next.rd = (s_reg.rd == AW'(DEPTH - 1)) ? '0 : s_reg.rd + 1'b1;
      end
      s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule

// File: vcu_uart_flow_control.sv
// Contract
// - After reset the port runs at 115200 bit/s, 8N1, with both handshake lines off.
// - Any bit rate from 9600 to 921600 bit/s is accepted for both directions.
// - With transmit-side handshake on, the permit line is deasserted while the buffer is full.
// - With receive-side handshake on, no new character is sent while the target is not ready.
// - A character already started is finished; only later characters are held back.
// - In mode none the permit line is undriven and the ready line is ignored.
// - In throttle-only mode the permit line is driven and the ready line is ignored.
// - In gate-only mode the permit line is undriven and sending waits for ready.
// - In combined mode the device both throttles the target and waits for ready.
//
// Implementation choices: the address map and the address-and-strobe port.
module vcu_uart_flow_control
   import vcu_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              sys_rst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [31:0]            reg_rdata,
   input  wire logic              target_txd,
   output logic                   target_rxd,
   output logic                   target_permit_n,
   output logic                   target_permit_oe,
   input  wire logic              target_ready_n
);

   typedef struct packed {
      vcu_mode_t   mode;
      logic [15:0] div;
      logic [7:0]  tx_hold;
      logic        tx_hold_full;
      vcu_fsm_t    tx_st;
      logic [15:0] tx_cnt;
      logic [2:0]  tx_bit;
      logic [7:0]  tx_sh;
      vcu_fsm_t    rx_st;
      logic [15:0] rx_cnt;
      logic [2:0]  rx_bit;
      logic [7:0]  rx_sh;
      logic        rx_push;
      logic [7:0]  rx_byte;
      logic        frame_err;
      logic        overrun;
      logic [1:0]  txd_sync;
      logic [1:0]  rdy_sync;
      logic        txd_line;
      logic        permit_n;
      logic        permit_oe;
      logic [31:0] rd_data;
   } vcu_state_t;

   vcu_state_t       s_reg;
   vcu_state_t       s_next;
   logic             fifo_in_ready;
   logic             fifo_out_valid;
   logic             fifo_pop;
   logic [7:0]       fifo_out_data;
   logic [CNT_W-1:0] fifo_count;
   logic             line_in;
   logic             ready;

   function automatic logic [15:0] clamp_div(input logic [31:0] w);
      if (w < 32'(DIV_LOW)) begin
         return DIV_LOW;
      end
      if (w > 32'(DIV_HIGH)) begin
         return DIV_HIGH;
      end
      return w[15:0];
   endfunction

   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
      return a == r;
   endfunction

   vcu_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .in_valid  (s_reg.rx_push),
      .in_ready  (fifo_in_ready),
      .in_data   (s_reg.rx_byte),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data),
      .count     (fifo_count)
   );

   assign line_in          = s_reg.txd_sync[1];
   assign ready            = !s_reg.rdy_sync[1];
   assign reg_rdata        = s_reg.rd_data;
   assign target_rxd       = s_reg.txd_line;
   assign target_permit_n  = s_reg.permit_n;
   assign target_permit_oe = s_reg.permit_oe;

   always_comb begin
      s_next          = s_reg;
      fifo_pop        = 1'b0;
      s_next.rd_data  = '0;
      s_next.rx_push  = 1'b0;
      s_next.txd_sync = {s_reg.txd_sync[0], target_txd};
      s_next.rdy_sync = {s_reg.rdy_sync[0], target_ready_n};

      // Register writes
      if (reg_wr) begin
         if (addr_is(reg_addr, REG_CTRL)) begin
            s_next.mode = vcu_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]);
         end else if (addr_is(reg_addr, REG_BAUD)) begin
            s_next.div = clamp_div(reg_wdata);
         end else if (addr_is(reg_addr, REG_TXDATA) && !s_reg.tx_hold_full) begin
            s_next.tx_hold      = reg_wdata[7:0];
            s_next.tx_hold_full = 1'b1;
         end else if (addr_is(reg_addr, REG_STATUS)) begin
            if (reg_wdata[ST_FRAME_ERR]) begin
               s_next.frame_err = 1'b0;
            end
            if (reg_wdata[ST_OVERRUN]) begin
               s_next.overrun = 1'b0;
            end
         end
      end

      // Register reads
      if (reg_rd) begin
         if (addr_is(reg_addr, REG_CTRL)) begin
            s_next.rd_data[CTRL_MODE_LSB +: 2] = s_reg.mode;
         end else if (addr_is(reg_addr, REG_BAUD)) begin
            s_next.rd_data[15:0] = s_reg.div;
         end else if (addr_is(reg_addr, REG_TXDATA)) begin
            s_next.rd_data[7:0] = s_reg.tx_hold;
         end else if (addr_is(reg_addr, REG_RXDATA)) begin
            s_next.rd_data[7:0]         = fifo_out_data;
            s_next.rd_data[RXD_VALID_BIT] = fifo_out_valid;
            fifo_pop                      = fifo_out_valid;
         end else if (addr_is(reg_addr, REG_STATUS)) begin
            s_next.rd_data[ST_RX_AVAIL]  = fifo_out_valid;
            s_next.rd_data[ST_RX_FULL]   = !fifo_in_ready;
            s_next.rd_data[ST_TX_HOLD]   = s_reg.tx_hold_full;
            s_next.rd_data[ST_TX_BUSY]   = s_reg.tx_st != VCU_IDLE;
            s_next.rd_data[ST_FRAME_ERR] = s_reg.frame_err;
            s_next.rd_data[ST_OVERRUN]   = s_reg.overrun;
            s_next.rd_data[ST_READY]     = ready;
            s_next.rd_data[ST_PERMIT]    = s_reg.permit_oe && !s_reg.permit_n;
            s_next.rd_data[ST_COUNT_LSB +: CNT_W] = fifo_count;
         end
      end

      // Transmitter toward the target
      unique case (s_reg.tx_st)
         VCU_IDLE: begin
            s_next.txd_line = LINE_IDLE;
            if (s_reg.tx_hold_full && (!gate_on(s_reg.mode) || ready)) begin
               s_next.tx_st        = VCU_START;
               s_next.tx_sh        = s_reg.tx_hold;
               s_next.tx_hold_full = 1'b0;
               s_next.tx_cnt       = s_reg.div - 16'h0001;
               s_next.txd_line     = LINE_START;
            end
         end
         VCU_START: begin
            if (s_reg.tx_cnt == '0) begin
               s_next.tx_st    = VCU_DATA;
               s_next.tx_bit   = '0;
               s_next.tx_cnt   = s_reg.div - 16'h0001;
               s_next.txd_line = s_reg.tx_sh[0];
            end else begin
               s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
            end
         end
         VCU_DATA: begin
            // Ready is not looked at here, the started character runs out
            if (s_reg.tx_cnt == '0) begin
               s_next.tx_cnt = s_reg.div - 16'h0001;
               s_next.tx_sh  = {1'b0, s_reg.tx_sh[7:1]};
               if (s_reg.tx_bit == LAST_BIT) begin
                  s_next.tx_st    = VCU_STOP;
                  s_next.txd_line = LINE_IDLE;
               end else begin
                  s_next.tx_bit   = s_reg.tx_bit + 3'h1;
                  s_next.txd_line = s_reg.tx_sh[1];
               end
            end else begin
               s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
            end
         end
         VCU_STOP: begin
            if (s_reg.tx_cnt == '0) begin
               s_next.tx_st = VCU_IDLE;
            end else begin
               s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
            end
         end
      endcase

      // Receiver from the target
      unique case (s_reg.rx_st)
         VCU_IDLE: begin
            if (line_in == LINE_START) begin
               s_next.rx_st  = VCU_START;
               s_next.rx_cnt = {1'b0, s_reg.div[15:1]};
            end
         end
         VCU_START: begin
            if (s_reg.rx_cnt == '0) begin
               s_next.rx_st  = (line_in == LINE_START) ? VCU_DATA : VCU_IDLE;
               s_next.rx_bit = '0;
               s_next.rx_cnt = s_reg.div - 16'h0001;
            end else begin
               s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
            end
         end
         VCU_DATA: begin
            if (s_reg.rx_cnt == '0) begin
               s_next.rx_sh  = {line_in, s_reg.rx_sh[7:1]};
               s_next.rx_cnt = s_reg.div - 16'h0001;
               s_next.rx_bit = s_reg.rx_bit + 3'h1;
               if (s_reg.rx_bit == LAST_BIT) begin
                  s_next.rx_st = VCU_STOP;
               end
            end else begin
               s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
            end
         end
         VCU_STOP: begin
            if (s_reg.rx_cnt == '0) begin
               s_next.rx_st = VCU_IDLE;
               if (line_in == LINE_IDLE) begin
                  s_next.rx_push = 1'b1;
                  s_next.rx_byte = s_reg.rx_sh;
               end else begin
                  s_next.frame_err = 1'b1;
               end
            end else begin
               s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
            end
         end
      endcase

      // Buffer overflow, set wins over a clear
      if (s_reg.rx_push && !fifo_in_ready) begin
         s_next.overrun = 1'b1;
      end

      // Permit line toward the target
      s_next.permit_oe = throttle_on(s_reg.mode);
      s_next.permit_n  = throttle_on(s_reg.mode) ? !fifo_in_ready : 1'b1;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s_reg          <= '0;
         s_reg.mode     <= MODE_RESET;
         s_reg.div      <= DIV_DEFAULT;
         s_reg.txd_line <= LINE_IDLE;
         s_reg.permit_n <= 1'b1;
         s_reg.txd_sync <= 2'b11;
         s_reg.rdy_sync <= 2'b11;
      end else begin
         s_reg <= s_next;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   property p_reset_default;
      $past(sys_rst) |-> (s_reg.mode == VCU_HS_NONE) && (s_reg.div == DIV_DEFAULT)
                         && !target_permit_oe && target_rxd;
   endproperty
   a_reset_default: assert property (p_reset_default)
      else $error("Port not at default after reset");

   property p_div_range;
      (s_reg.div >= DIV_LOW) && (s_reg.div <= DIV_HIGH);
   endproperty
   a_div_range: assert property (p_div_range)
      else $error("Bit rate divisor out of range");

   property p_permit_full;
      throttle_on(s_reg.mode) && !fifo_in_ready |=> target_permit_oe && target_permit_n;
   endproperty
   a_permit_full: assert property (p_permit_full)
      else $error("Permit not withdrawn on full buffer");

   property p_gate_hold;
      (s_reg.tx_st == VCU_IDLE) && gate_on(s_reg.mode) && !ready |=> s_reg.tx_st == VCU_IDLE;
   endproperty
   a_gate_hold: assert property (p_gate_hold)
      else $error("Character started while target not ready");

   property p_finish_char;
      (s_reg.tx_st == VCU_DATA) |=> (s_reg.tx_st == VCU_DATA) || (s_reg.tx_st == VCU_STOP);
   endproperty
   a_finish_char: assert property (p_finish_char)
      else $error("Character aborted");

   property p_undriven;
      !throttle_on(s_reg.mode) ##1 !throttle_on(s_reg.mode) |-> !target_permit_oe;
   endproperty
   a_undriven: assert property (p_undriven)
      else $error("Permit line driven while throttling off");

   property p_gate_only;
      (s_reg.mode == VCU_HS_GATE) && (s_reg.tx_st == VCU_IDLE) && s_reg.tx_hold_full && ready
         |=> (s_reg.tx_st == VCU_START) && !target_permit_oe;
   endproperty
   a_gate_only: assert property (p_gate_only)
      else $error("Gate-only send not started or permit driven");

   property p_ignore_ready;
      (s_reg.tx_st == VCU_IDLE) && s_reg.tx_hold_full && !gate_on(s_reg.mode)
         |=> (s_reg.tx_st == VCU_START) && !target_rxd;
   endproperty
   a_ignore_ready: assert property (p_ignore_ready)
      else $error("Send held back though ready is ignored");

   property p_both_mode;
      (s_reg.mode == VCU_HS_BOTH) && fifo_in_ready |=> target_permit_oe && !target_permit_n;
   endproperty
   a_both_mode: assert property (p_both_mode)
      else $error("Permit not granted with room in buffer");

   property p_frame_stop;
      (s_reg.tx_st == VCU_DATA) ##1 (s_reg.tx_st == VCU_STOP) |-> target_rxd;
   endproperty
   a_frame_stop: assert property (p_frame_stop)
      else $error("Stop bit not high");

   property p_read_once;
      !$past(reg_rd) |-> reg_rdata == '0;
   endproperty
   a_read_once: assert property (p_read_once)
      else $error("Read data outside answer cycle");

   c_gated_send: cover property (gate_on(s_reg.mode) && ready && (s_reg.tx_st == VCU_START));
   c_rx_push: cover property (s_reg.rx_push && fifo_in_ready);
   c_throttle: cover property (target_permit_oe && target_permit_n);
   c_overrun: cover property (s_reg.rx_push && !fifo_in_ready);

endmodule

// File: vcu_target_model.sv
module vcu_target_model #(
   parameter int DIV = 271
) (
   input  wire logic clock,
   input  wire logic rx_line,
   output logic      tx_line,
   input  wire logic permit_line,
   input  wire logic ready_req,
   output logic      ready_n
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] rx_q[$];
   int         frame_bad = 0;

   initial tx_line = 1'b1;

   // Ready line always driven, low means room
   assign ready_n = !ready_req;

   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      while (permit_line === 1'b1) begin
         @(posedge clock);
      end
      for (int i = 0; i < 10; i++) begin
         tx_line <= f[i];
         repeat (DIV) @(posedge clock);
      end
   endtask

   // Receiver with unbounded room, so one more char always fits
   always begin
      logic [7:0] v;
      @(negedge rx_line);
      repeat (DIV / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         repeat (DIV) @(posedge clock);
         v = {rx_line, v[7:1]};
      end
      repeat (DIV) @(posedge clock);
      if (rx_line !== 1'b1) begin
         frame_bad++;
      end
      rx_q.push_back(v);
   end
endmodule

// File: vcu_uart_flow_control_tb_top.sv
module vcu_uart_flow_control_tb_top
   import vcu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              clock;
   logic              sys_rst;
   logic [ADDR_W-1:0] reg_addr;
   logic [31:0]       reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [31:0]       reg_rdata;
   logic              target_txd;
   logic              target_rxd;
   logic              target_permit_n;
   logic              target_permit_oe;
   logic              target_ready_n;
   logic              permit_line;
   logic              ready_req;
   logic [31:0]       st;
   int                n_errors = 0;
   int                n_tests = 0;

   // Pull-down lets the target send while the pin floats
   assign permit_line = target_permit_oe ? target_permit_n : 1'b0;

   vcu_uart_flow_control vcu_uart_flow_control_inst (
      .clock            (clock),
      .sys_rst          (sys_rst),
      .reg_addr         (reg_addr),
      .reg_wdata        (reg_wdata),
      .reg_wr           (reg_wr),
      .reg_rd           (reg_rd),
      .reg_rdata        (reg_rdata),
      .target_txd       (target_txd),
      .target_rxd       (target_rxd),
      .target_permit_n  (target_permit_n),
      .target_permit_oe (target_permit_oe),
      .target_ready_n   (target_ready_n)
   );

   vcu_target_model #(.DIV(271)) vcu_target_model_inst (
      .clock       (clock),
      .rx_line     (target_rxd),
      .tx_line     (target_txd),
      .permit_line (permit_line),
      .ready_req   (ready_req),
      .ready_n     (target_ready_n)
   );

   always #2 clock = !clock;

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic hang(input string what);
      n_errors++;
      $display("Error %s wait ran out", what);
      end_of_test();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr    <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd   <= 1'b0;
      @(posedge clock);
      d = reg_rdata;
   endtask

   task automatic wait_rx(input int n, input int lim);
      for (int i = 0; i < lim && vcu_target_model_inst.rx_q.size() < n; i++) begin
         @(posedge clock);
      end
      if (vcu_target_model_inst.rx_q.size() < n) begin
         hang("target receive");
      end
   endtask

   task automatic got(input logic [7:0] exp);
      chk("byte at target", 32'(vcu_target_model_inst.rx_q.pop_front()), 32'(exp));
   endtask

   task automatic t_reset();
      rd(REG_CTRL, st);
      chk("ctrl", st, 32'h0000_0000);
      rd(REG_BAUD, st);
      chk("baud", st, 32'(DIV_DEFAULT));
      rd(8'h20, st);
      chk("unmapped", st, 32'h0000_0000);
      wr(REG_STATUS, 32'h0000_0030);
      rd(REG_STATUS, st);
      chk("status", st, 32'h0000_0000);
      chk("permit oe", 32'(target_permit_oe), 32'h0000_0000);
      chk("idle line", 32'(target_rxd), 32'h0000_0001);
      wr(REG_BAUD, 32'h0000_0064);
      rd(REG_BAUD, st);
      chk("baud low clamp", st, 32'(DIV_LOW));
      wr(REG_BAUD, 32'h0000_7530);
      rd(REG_BAUD, st);
      chk("baud high clamp", st, 32'(DIV_HIGH));
      wr(REG_BAUD, 32'(DIV_LOW));
      $display("Test reset done");
   endtask

   task automatic t_frame();
      ready_req <= 1'b0;
      wr(REG_TXDATA, 32'h0000_00A5);
      st = 32'h0000_0004;
      for (int i = 0; i < 10 && st[ST_TX_HOLD] !== 1'b0; i++) begin
         rd(REG_STATUS, st);
      end
      chk("hold free", 32'(st[ST_TX_HOLD]), 32'h0000_0000);
      wr(REG_TXDATA, 32'h0000_003C);
      wait_rx(2, 6000);
      got(8'hA5);
      got(8'h3C);
      chk("stop bits", 32'(vcu_target_model_inst.frame_bad), 32'h0000_0000);
      $display("Test frame done");
   endtask

   task automatic t_gate();
      wr(REG_CTRL, 32'(VCU_HS_GATE));
      wr(REG_TXDATA, 32'h0000_005A);
      repeat (300) @(posedge clock);
      rd(REG_STATUS, st);
      chk("gate busy", 32'(st[ST_TX_BUSY]), 32'h0000_0000);
      chk("gate hold", 32'(st[ST_TX_HOLD]), 32'h0000_0001);
      chk("held", 32'(vcu_target_model_inst.rx_q.size()), 32'h0000_0000);
      chk("permit oe", 32'(target_permit_oe), 32'h0000_0000);
      ready_req <= 1'b1;
      wait_rx(1, 3500);
      got(8'h5A);
      $display("Test gate done");
   endtask

   task automatic t_midchar();
      wr(REG_CTRL, 32'(VCU_HS_BOTH));
      repeat (2) @(posedge clock);
      chk("permit oe", 32'(target_permit_oe), 32'h0000_0001);
      chk("permit", 32'(target_permit_n), 32'h0000_0000);
      wr(REG_TXDATA, 32'h0000_00C3);
      repeat (600) @(posedge clock);
      ready_req <= 1'b0;
      wr(REG_TXDATA, 32'h0000_0081);
      wait_rx(1, 3000);
      got(8'hC3);
      repeat (300) @(posedge clock);
      rd(REG_STATUS, st);
      chk("both busy", 32'(st[ST_TX_BUSY]), 32'h0000_0000);
      chk("held", 32'(vcu_target_model_inst.rx_q.size()), 32'h0000_0000);
      ready_req <= 1'b1;
      wait_rx(1, 3500);
      got(8'h81);
      $display("Test midchar done");
   endtask

   task automatic t_throttle();
      int i;
      wr(REG_CTRL, 32'(VCU_HS_THROTTLE));
      ready_req <= 1'b0;
      repeat (2) @(posedge clock);
      chk("permit oe", 32'(target_permit_oe), 32'h0000_0001);
      chk("permit", 32'(target_permit_n), 32'h0000_0000);
      fork
         for (int k = 0; k < 32; k++) begin
            vcu_target_model_inst.send_byte(8'(8'h40 + k));
         end
      join_none
      wr(REG_TXDATA, 32'h0000_0011);
      wait_rx(1, 3500);
      got(8'h11);
      for (i = 0; i < 90000 && target_permit_n !== 1'b1; i++) begin
         @(posedge clock);
      end
      if (target_permit_n !== 1'b1) begin
         hang("buffer full");
      end
      rd(REG_STATUS, st);
      chk("fifo count", 32'(st[13:8]), 32'h0000_0020);
      chk("fifo full", 32'(st[ST_RX_FULL]), 32'h0000_0001);
      rd(REG_RXDATA, st);
      chk("oldest byte", st, 32'h0000_0140);
      repeat (2) @(posedge clock);
      chk("permit back", 32'(target_permit_n), 32'h0000_0000);
      wr(REG_CTRL, 32'(VCU_HS_NONE));
      repeat (2) @(posedge clock);
      chk("permit oe", 32'(target_permit_oe), 32'h0000_0000);
      $display("Test throttle done");
   endtask

   initial begin
      clock     = 1'b0;
      sys_rst   = 1'b1;
      reg_addr  = '0;
      reg_wdata = '0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      ready_req = 1'b0;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      t_reset();
      t_frame();
      t_gate();
      t_midchar();
      t_throttle();
      end_of_test();
   end
endmodule
